// ==== rtl/adbd_ctrl.sv ====
// Two-block asynchronous DRAM controller with per-block decode and strobe timing.
// Assumes a same-clock access requester and a register master with one-cycle read data.
//
// Chosen here: the address map and the plain strobed port.
module adbd_ctrl import adbd_pkg::*; #(
	parameter int REFRESH_CYCLES = ADBD_REFRESH_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Access request
	input wire logic acc_req,
	input wire logic [31:0] acc_addr,
	input wire logic [1:0] acc_size,
	input wire logic acc_write,
	output logic acc_ready,
	output logic acc_ack,
	output logic acc_done,
	output logic acc_miss,
	// Memory strobes, active low
	output logic [1:0] ras_n,
	output logic [3:0] cas_n,
	output logic dramw_n
);

	// Refuses refresh intervals below 16 or above 65535 clocks for the 16-bit timer.
	if (REFRESH_CYCLES < 16 || REFRESH_CYCLES > 65535) begin : g_bad_refresh
		$error("REFRESH_CYCLES out of range");
	end

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// [RULE_17] [RULE_18] Beats per access from size and port width.
	function automatic logic [4:0] beat_count(input logic [1:0] size, input logic [1:0] ps);
		logic [4:0] bytes;
		bytes = 5'd4;
		unique case (size)
			ADBD_SZ_BYTE: bytes = 5'd1;
			ADBD_SZ_WORD: bytes = 5'd2;
			ADBD_SZ_LINE: bytes = 5'd16;
			default: bytes = 5'd4;
		endcase
		if (ps == ADBD_PS_32) begin
			beat_count = (bytes > 5'd4) ? (bytes >> 2) : 5'd1;
		end else if (ps == ADBD_PS_8) begin
			beat_count = bytes;
		end else begin
			beat_count = (bytes > 5'd2) ? (bytes >> 1) : 5'd1;
		end
	endfunction

	// [RULE_17] Column strobe lanes; lane 0 is the most significant byte.
	function automatic logic [3:0] cas_lanes(input logic [1:0] size, input logic [1:0] ps, input logic [1:0] a);
		logic [3:0] lanes;
		lanes = 4'h1;
		if (ps == ADBD_PS_32) begin
			unique case (size)
				ADBD_SZ_BYTE: lanes = 4'(4'h1 << a);
				ADBD_SZ_WORD: lanes = a[1] ? 4'hC : 4'h3;
				default: lanes = 4'hF;
			endcase
		end else if (ps != ADBD_PS_8) begin
			if (size == ADBD_SZ_BYTE) begin
				lanes = a[0] ? 4'h2 : 4'h1;
			end else begin
				lanes = 4'h3;
			end
		end
		cas_lanes = lanes;
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] ctrl_reg [2];
	logic [ADBD_ORIGIN_W-1:0] mask_reg [2];
	logic sync_mode_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	adbd_state_t state_reg;
	adbd_state_t state_next;
	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;
	logic [4:0] beats_reg;
	logic [4:0] beats_next;
	logic blk_reg;
	logic page_reg;
	logic [3:0] lanes_reg;
	logic write_reg;
	logic req_pend_reg;
	logic [31:0] req_addr_reg;
	logic [1:0] req_size_reg;
	logic req_write_reg;
	logic [15:0] ref_timer_reg;
	logic ref_pend_reg;
	logic [1:0] ref_blk_reg;
	logic ack_reg;
	logic edo_ack_reg;
	logic done_reg;
	logic miss_reg;
	logic ready_reg;
	logic [1:0] ras_n_reg;
	logic [3:0] cas_n_reg;
	logic dramw_n_reg;
	logic [1:0] ras_n_next;
	logic [3:0] cas_n_next;
	logic [1:0] hit;
	logic [1:0] upkeep;
	logic take;
	logic start_ref;
	logic beat_end;
	logic last_beat;
	logic [31:0] cur_ctrl;
	logic [1:0] cur_casw;
	logic [1:0] cur_prech;
	logic cur_skew;
	logic cur_rcd;
	logic cur_edo;
	logic [1:0] sel_ps;
	logic [1:0] sel_pm;
	logic sel_blk;

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			// [RULE_08] Upkeep bit clear after reset.
			ctrl_reg[0] <= ADBD_CTRL_RESET;
			ctrl_reg[1] <= ADBD_CTRL_RESET;
		end else if (reg_wr && reg_addr == ADBD_OFS_CTRL0) begin
			ctrl_reg[0] <= reg_wdata & ADBD_CTRL_WMASK;
		end else if (reg_wr && reg_addr == ADBD_OFS_CTRL1) begin
			ctrl_reg[1] <= reg_wdata & ADBD_CTRL_WMASK;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mask_reg[0] <= ADBD_MASK_RESET[ADBD_ORIGIN_LSB +: ADBD_ORIGIN_W];
			mask_reg[1] <= ADBD_MASK_RESET[ADBD_ORIGIN_LSB +: ADBD_ORIGIN_W];
		end else if (reg_wr && reg_addr == ADBD_OFS_MASK0) begin
			mask_reg[0] <= reg_wdata[ADBD_ORIGIN_LSB +: ADBD_ORIGIN_W];
		end else if (reg_wr && reg_addr == ADBD_OFS_MASK1) begin
			mask_reg[1] <= reg_wdata[ADBD_ORIGIN_LSB +: ADBD_ORIGIN_W];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_mode_reg <= 1'b0;
		end else if (reg_wr && reg_addr == ADBD_OFS_MODE) begin
			sync_mode_reg <= reg_wdata[ADBD_SYNC_BIT];
		end
	end

	always_comb begin
		rdata_next = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				ADBD_OFS_CTRL0: rdata_next = ctrl_reg[0];
				ADBD_OFS_CTRL1: rdata_next = ctrl_reg[1];
				ADBD_OFS_MASK0: rdata_next = {mask_reg[0], 18'h0_0000};
				ADBD_OFS_MASK1: rdata_next = {mask_reg[1], 18'h0_0000};
				ADBD_OFS_MODE: rdata_next = {31'h0000_0000, sync_mode_reg};
				ADBD_OFS_STATUS: rdata_next = {16'h0000, ref_blk_reg, ref_pend_reg, blk_reg,
					beats_reg, state_reg, 4'h0};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0000_0000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_dec
			// [RULE_21] One independent decoder per block.
			adbd_hit_decode u_dec (
				.addr_hi(req_addr_reg[ADBD_ORIGIN_LSB +: ADBD_ORIGIN_W]),
				.region_origin_bits(ctrl_reg[gi][ADBD_ORIGIN_LSB +: ADBD_ORIGIN_W]),
				.region_origin_ignore_bits(mask_reg[gi]),
				.hit(hit[gi])
			);
			// [RULE_07] Per-block refresh enable.
			assign upkeep[gi] = ctrl_reg[gi][ADBD_UPKEEP_BIT];
		end
	endgenerate

	// Block 0 is taken when both hit; overlapping regions are a software fault.
	assign sel_blk = ~hit[0];
	assign sel_ps = ctrl_reg[sel_blk][ADBD_PSIZE_LSB +: 2];
	assign sel_pm = ctrl_reg[sel_blk][ADBD_PAGE_LSB +: 2];
	assign cur_ctrl = ctrl_reg[blk_reg];
	assign cur_casw = cur_ctrl[ADBD_CASW_LSB +: 2];
	assign cur_prech = cur_ctrl[ADBD_PRECH_LSB +: 2];
	assign cur_skew = cur_ctrl[ADBD_SKEW_BIT];
	assign cur_rcd = cur_ctrl[ADBD_RCD_BIT];
	assign cur_edo = cur_ctrl[ADBD_EDO_BIT];

	// [RULE_01] Sequencer serves only in asynchronous mode.
	assign take = (state_reg == ADBD_IDLE) && req_pend_reg && !ref_pend_reg && !sync_mode_reg;
	assign start_ref = (state_reg == ADBD_IDLE) && ref_pend_reg;
	assign beat_end = (state_reg == ADBD_COL) && (cnt_reg == 2'h0);
	assign last_beat = (beats_reg == 5'd1);

	// ----------------------------------------
	// Access request capture
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			req_pend_reg <= 1'b0;
			req_addr_reg <= 32'h0000_0000;
			req_size_reg <= 2'h0;
			req_write_reg <= 1'b0;
		end else if (acc_req && ready_reg) begin
			req_pend_reg <= 1'b1;
			req_addr_reg <= acc_addr;
			req_size_reg <= acc_size;
			req_write_reg <= acc_write;
		end else if (take || (req_pend_reg && sync_mode_reg && state_reg == ADBD_IDLE)) begin
			req_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ready_reg <= 1'b0;
		end else begin
			ready_reg <= (state_next == ADBD_IDLE) && !req_pend_reg && !(acc_req && ready_reg);
		end
	end

	// ----------------------------------------
	// Refresh timer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ref_timer_reg <= 16'h0000;
			ref_pend_reg <= 1'b0;
			ref_blk_reg <= 2'h0;
		end else begin
			if (ref_timer_reg == 16'(REFRESH_CYCLES - 1)) begin
				ref_timer_reg <= 16'h0000;
			end else begin
				ref_timer_reg <= ref_timer_reg + 16'h0001;
			end
			// [RULE_07] Refresh only blocks with upkeep enabled; set wins over clear.
			if (ref_timer_reg == 16'(REFRESH_CYCLES - 1) && |upkeep && !sync_mode_reg) begin
				ref_pend_reg <= 1'b1;
			end else if (start_ref) begin
				ref_pend_reg <= 1'b0;
			end
			if (start_ref) begin
				ref_blk_reg <= upkeep;
			end
		end
	end

	// ----------------------------------------
	// Strobe sequencer
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		beats_next = beats_reg;
		unique case (state_reg)
			ADBD_IDLE: begin
				if (start_ref) begin
					state_next = ADBD_RCAS;
					cnt_next = 2'h0;
				end else if (take && |hit) begin
					state_next = ADBD_ROW;
					// [RULE_14] Row to column delay.
					cnt_next = ctrl_reg[sel_blk][ADBD_RCD_BIT] ? 2'h1 : 2'h0;
					// [RULE_18] Split into port-width beats.
					beats_next = beat_count(req_size_reg, sel_ps);
				end
			end
			ADBD_ROW: begin
				if (cnt_reg == 2'h0) begin
					state_next = ADBD_COL;
					// [RULE_09] Column strobe width.
					cnt_next = cur_casw;
				end else begin
					cnt_next = cnt_reg - 2'h1;
				end
			end
			ADBD_COL: begin
				if (cnt_reg != 2'h0) begin
					cnt_next = cnt_reg - 2'h1;
				end else if (!last_beat && page_reg) begin
					// [RULE_13] Page beat keeps row open with no skew.
					state_next = ADBD_ROW;
					cnt_next = 2'h0;
					beats_next = beats_reg - 5'd1;
				end else if (cur_skew && cur_casw != 2'h0) begin
					// [RULE_11] [RULE_12] Row negates one clock early.
					state_next = ADBD_SKEW;
					beats_next = beats_reg - 5'd1;
				end else begin
					// [RULE_10] Row precharge.
					state_next = ADBD_PRE;
					cnt_next = cur_prech;
					beats_next = beats_reg - 5'd1;
				end
			end
			ADBD_SKEW: begin
				state_next = ADBD_PRE;
				cnt_next = cur_prech;
			end
			ADBD_PRE: begin
				if (cnt_reg != 2'h0) begin
					cnt_next = cnt_reg - 2'h1;
				end else if (beats_reg != 5'd0) begin
					state_next = ADBD_ROW;
					cnt_next = cur_rcd ? 2'h1 : 2'h0;
				end else begin
					state_next = ADBD_IDLE;
				end
			end
			ADBD_RCAS: begin
				state_next = ADBD_RRAS;
				cnt_next = ADBD_REF_RAS_CLKS;
			end
			ADBD_RRAS: begin
				if (cnt_reg == 2'h0) begin
					state_next = ADBD_RPRE;
					cnt_next = ADBD_REF_PRE_CLKS;
				end else begin
					cnt_next = cnt_reg - 2'h1;
				end
			end
			ADBD_RPRE: begin
				if (cnt_reg == 2'h0) begin
					state_next = ADBD_IDLE;
				end else begin
					cnt_next = cnt_reg - 2'h1;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= ADBD_IDLE;
			cnt_reg <= 2'h0;
			beats_reg <= 5'd0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			beats_reg <= beats_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			blk_reg <= 1'b0;
			page_reg <= 1'b0;
			lanes_reg <= 4'h0;
			write_reg <= 1'b0;
		end else if (take && |hit) begin
			blk_reg <= sel_blk;
			// [RULE_19] Burst page only for line bursts; continuous for any split.
			page_reg <= (sel_pm == ADBD_PM_BURST && req_size_reg == ADBD_SZ_LINE) || (sel_pm == ADBD_PM_CONT);
			lanes_reg <= cas_lanes(req_size_reg, sel_ps, req_addr_reg[1:0]);
			write_reg <= req_write_reg;
		end
	end

	// ----------------------------------------
	// Termination
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
			edo_ack_reg <= 1'b0;
			done_reg <= 1'b0;
			miss_reg <= 1'b0;
		end else begin
			// [RULE_15] Extended data out acknowledges one clock after column end.
			edo_ack_reg <= beat_end && cur_edo;
			ack_reg <= (beat_end && !cur_edo) || edo_ack_reg;
			done_reg <= (state_reg == ADBD_PRE) && (cnt_reg == 2'h0) && (beats_reg == 5'd0);
			// [RULE_21] A cycle hitting neither block is refused.
			miss_reg <= (take && !(|hit)) || (req_pend_reg && sync_mode_reg && state_reg == ADBD_IDLE);
		end
	end

	// ----------------------------------------
	// Strobe outputs
	// ----------------------------------------
	always_comb begin
		ras_n_next = 2'b11;
		cas_n_next = 4'hF;
		unique case (state_reg)
			ADBD_ROW: ras_n_next[blk_reg] = 1'b0;
			ADBD_COL: begin
				ras_n_next[blk_reg] = 1'b0;
				cas_n_next = ~lanes_reg;
			end
			ADBD_SKEW: cas_n_next = ~lanes_reg;
			ADBD_RCAS: cas_n_next = 4'h0;
			ADBD_RRAS: begin
				cas_n_next = 4'h0;
				ras_n_next = ~ref_blk_reg;
			end
			default: ras_n_next = 2'b11;
		endcase
	end

	// [RULE_02] Strobes launched on the falling clock edge.
	always_ff @(negedge clk) begin
		if (!rst_n) begin
			ras_n_reg <= 2'b11;
			cas_n_reg <= 4'hF;
			dramw_n_reg <= 1'b1;
		end else begin
			ras_n_reg <= ras_n_next;
			cas_n_reg <= cas_n_next;
			dramw_n_reg <= !(write_reg && (state_reg == ADBD_ROW || state_reg == ADBD_COL ||
				state_reg == ADBD_SKEW));
		end
	end

	assign reg_rdata = rdata_reg;
	assign acc_ready = ready_reg;
	assign acc_ack = ack_reg;
	assign acc_done = done_reg;
	assign acc_miss = miss_reg;
	assign ras_n = ras_n_reg;
	assign cas_n = cas_n_reg;
	assign dramw_n = dramw_n_reg;

endmodule

// ==== rtl/adbd_pkg.sv ====
// Constants, field layouts and state codes for the two-block asynchronous DRAM decode and timing block.
// Assumes a single 40 MHz clock and a simple strobed register port with one-cycle read latency.
//
// Function
// [RULE_01] Block layouts valid only in asynchronous mode
// [RULE_02] Row and column strobes change on falling edge
// [RULE_03] Compare origin bits 31..18 with address
// [RULE_04] Hit when all match or mismatches ignored
// [RULE_05] Ignore bit one drops address bit from decode
// [RULE_06] Software keeps block regions from overlapping
// [RULE_07] Upkeep bit 15 enables refresh per block
// [RULE_08] Upkeep bit reads zero after reset
// [RULE_09] Column strobe width one to four clocks
// [RULE_10] Row precharge one to four clocks
// [RULE_11] Skew bit negates row one clock early
// [RULE_12] Skew ignored for one-clock column strobe
// [RULE_13] Skew not applied to page continuation beats
// [RULE_14] Row to column delay one or two clocks
// [RULE_15] Bit 6 enables extended data out timing
// [RULE_16] Software enables extended data only if supported
// [RULE_17] Port width code 00=32, 01=8, 1x=16
// [RULE_18] Split wide transfers into narrower memory beats
// [RULE_19] Page style 00 none, 01 burst, 11 continuous
// [RULE_20] Software writes zero to reserved bits
// [RULE_21] Blocks independent; double miss not handled
package adbd_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADBD_OFS_CTRL0 = 8'h00;
	localparam logic [7:0] ADBD_OFS_CTRL1 = 8'h04;
	localparam logic [7:0] ADBD_OFS_MASK0 = 8'h08;
	localparam logic [7:0] ADBD_OFS_MASK1 = 8'h0C;
	localparam logic [7:0] ADBD_OFS_MODE = 8'h10;
	localparam logic [7:0] ADBD_OFS_STATUS = 8'h14;

	// ----------------------------------------
	// Block control register fields
	// ----------------------------------------
	localparam int ADBD_ORIGIN_LSB = 18;
	localparam int ADBD_ORIGIN_W = 14;
	localparam int ADBD_UPKEEP_BIT = 15;
	localparam int ADBD_CASW_LSB = 12;
	localparam int ADBD_PRECH_LSB = 10;
	localparam int ADBD_SKEW_BIT = 9;
	localparam int ADBD_RCD_BIT = 8;
	localparam int ADBD_EDO_BIT = 6;
	localparam int ADBD_PSIZE_LSB = 4;
	localparam int ADBD_PAGE_LSB = 2;
	localparam logic [31:0] ADBD_CTRL_WMASK = 32'hFFFC_BF7C;
	localparam logic [31:0] ADBD_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] ADBD_MASK_RESET = 32'h0000_0000;
	localparam int ADBD_SYNC_BIT = 0;

	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	localparam logic [1:0] ADBD_PS_32 = 2'b00;
	localparam logic [1:0] ADBD_PS_8 = 2'b01;
	localparam logic [1:0] ADBD_PM_BURST = 2'b01;
	localparam logic [1:0] ADBD_PM_CONT = 2'b11;
	localparam logic [1:0] ADBD_SZ_LONG = 2'b00;
	localparam logic [1:0] ADBD_SZ_BYTE = 2'b01;
	localparam logic [1:0] ADBD_SZ_WORD = 2'b10;
	localparam logic [1:0] ADBD_SZ_LINE = 2'b11;

	// ----------------------------------------
	// Timing counts
	// ----------------------------------------
	localparam int ADBD_REFRESH_CYCLES = 625;
	localparam logic [1:0] ADBD_REF_RAS_CLKS = 2'h1;
	localparam logic [1:0] ADBD_REF_PRE_CLKS = 2'h1;

	typedef enum logic [2:0] {
		ADBD_IDLE = 3'b000,
		ADBD_ROW = 3'b001,
		ADBD_COL = 3'b011,
		ADBD_SKEW = 3'b010,
		ADBD_PRE = 3'b110,
		ADBD_RCAS = 3'b111,
		ADBD_RRAS = 3'b101,
		ADBD_RPRE = 3'b100
	} adbd_state_t;

endpackage

// ==== rtl/adbd_hit_decode.sv ====
// Address compare for one memory block.
// Assumes the address and the register fields are stable in the cycle of use.
module adbd_hit_decode import adbd_pkg::*; (
	// Address of the current cycle
	input wire logic [ADBD_ORIGIN_W-1:0] addr_hi,
	// Block settings
	input wire logic [ADBD_ORIGIN_W-1:0] region_origin_bits,
	input wire logic [ADBD_ORIGIN_W-1:0] region_origin_ignore_bits,
	// Result
	output logic hit
);

	// [RULE_03] [RULE_04] [RULE_05] Masked bitwise compare.
	always_comb begin
		hit = &((~(addr_hi ^ region_origin_bits)) | region_origin_ignore_bits);
	end

endmodule

// ==== test/adbd_props.sv ====
// Checker for the two-block decode and strobe timing controller.
// Assumes settings change only through register writes seen on its ports.
module adbd_props import adbd_pkg::*; #(
	parameter int REFRESH_CYCLES = ADBD_REFRESH_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Access port
	input wire logic acc_req,
	input wire logic [31:0] acc_addr,
	input wire logic [1:0] acc_size,
	input wire logic acc_write,
	input wire logic acc_ready,
	input wire logic acc_ack,
	input wire logic acc_done,
	input wire logic acc_miss,
	// Strobes
	input wire logic [1:0] ras_n,
	input wire logic [3:0] cas_n,
	input wire logic dramw_n
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIM = 2 * REFRESH_CYCLES + 300;
	logic [31:0] c0, c1, m0, m1;
	logic sync_on;
	logic [6:0] strb_rise;
	logic [2:0] cw_cnt, pc_cnt;
	logic [3:0] off_cnt;
	logic [15:0] rc0, rc1;
	wire [1:0] up = {c1[15], c0[15]};
	wire h0 = ((acc_addr[31:18] ^ c0[31:18]) & ~m0[31:18]) == 14'h0;
	wire h1 = ((acc_addr[31:18] ^ c1[31:18]) & ~m1[31:18]) == 14'h0;
	wire exp_miss = sync_on || !(h0 || h1);
	wire cw_on = !ras_n[0] && cas_n != 4'hF;
	// ----------------------------------------
	// Shadow settings and counters
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{c0, c1, m0, m1, sync_on} <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				ADBD_OFS_CTRL0: c0 <= reg_wdata;
				ADBD_OFS_CTRL1: c1 <= reg_wdata;
				ADBD_OFS_MASK0: m0 <= reg_wdata;
				ADBD_OFS_MASK1: m1 <= reg_wdata;
				ADBD_OFS_MODE: sync_on <= reg_wdata[ADBD_SYNC_BIT];
				default: ;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		strb_rise <= {ras_n, cas_n, dramw_n};
		cw_cnt <= cw_on ? cw_cnt + 3'h1 : 3'h0;
		pc_cnt <= (!ras_n[0] || !rst_n) ? 3'h0 : pc_cnt + {2'h0, pc_cnt != 3'h7};
		off_cnt <= (up == 2'h0 && acc_ready) ? off_cnt + {3'h0, off_cnt != 4'hF} : 4'h0;
		rc0 <= (c0[15] && !sync_on && ras_n[0]) ? rc0 + 16'h0001 : 16'h0000;
		rc1 <= (c1[15] && !sync_on && ras_n[1]) ? rc1 + 16'h0001 : 16'h0000;
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_strobe_fall_edge: assert property (@(negedge clk) {ras_n, cas_n, dramw_n} == strb_rise)
		else $error("strobe changed at a rising edge");
	a_miss_decode: assert property (acc_req && acc_ready && up == 2'h0 |-> ##2 acc_miss == $past(exp_miss, 2))
		else $error("block decode result wrong");
	a_ready_drop: assert property (acc_req && acc_ready |=> !acc_ready)
		else $error("ready stayed high after acceptance");
	a_miss_quiet: assert property (acc_miss |-> ras_n == 2'h3 && cas_n == 4'hF && !acc_ack)
		else $error("strobes active on a missed access");
	a_rcd_gap: assert property ($fell(ras_n[0]) && cas_n == 4'hF && up == 2'h0 |=>
		if (c0[8]) (cas_n == 4'hF ##1 cas_n != 4'hF) else (cas_n != 4'hF))
		else $error("row to column delay wrong");
	a_cas_width: assert property ($fell(cw_on) && up == 2'h0 |-> cw_cnt == {1'b0, c0[13:12]} + 3'h1)
		else $error("column strobe width wrong");
	a_edo_ack: assert property ($fell(cw_on) && up == 2'h0 |-> if (c0[6]) (!acc_ack ##1 acc_ack) else acc_ack)
		else $error("access acknowledge timing wrong");
	a_precharge_min: assert property ($fell(ras_n[0]) && up == 2'h0 |-> pc_cnt > {1'b0, c0[11:10]})
		else $error("row precharge too short");
	a_skew_release: assert property ($rose(ras_n[0]) && up == 2'h0 && c0[3:2] == 2'h0 |->
		if (c0[9] && c0[13:12] != 2'h0) (cas_n != 4'hF ##1 cas_n == 4'hF) else (cas_n == 4'hF))
		else $error("row and column release order wrong");
	a_refresh_off: assert property (off_cnt > 4'h7 |-> ras_n == 2'h3)
		else $error("row strobe while idle without upkeep");
	a_refresh_due: assert property (rc0 < LIM && rc1 < LIM)
		else $error("upkeep cycle missing");
endmodule

bind adbd_ctrl adbd_props #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_props (.clk(clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.acc_req(acc_req), .acc_addr(acc_addr), .acc_size(acc_size), .acc_write(acc_write),
	.acc_ready(acc_ready), .acc_ack(acc_ack), .acc_done(acc_done), .acc_miss(acc_miss),
	.ras_n(ras_n), .cas_n(cas_n), .dramw_n(dramw_n));

// ==== test/adbd_dram_model.sv ====
// Memory array model on the far side: counts row openings and column strobes.
// Assumes active low strobes that are settled at each rising clock edge.
module adbd_dram_model #(
	parameter bit EDO_CAPABLE = 1'b1
) (
	// Clock
	input wire logic clk,
	// Strobes
	input wire logic [1:0] ras_n,
	input wire logic [3:0] cas_n,
	input wire logic dramw_n,
	// Counts
	output int rows0,
	output int rows1,
	output int wrows,
	output int cols
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ras_q = 2'h3;
	logic [3:0] cas_q = 4'hF;
	initial {rows0, rows1, wrows, cols} = '0;
	always @(posedge clk) begin
		ras_q <= ras_n;
		cas_q <= cas_n;
		if (ras_q[0] && !ras_n[0]) rows0 <= rows0 + 1;
		if (ras_q[1] && !ras_n[1]) rows1 <= rows1 + 1;
		if ((ras_q & ~ras_n) != 2'h0 && !dramw_n) wrows <= wrows + 1;
		if (cas_q == 4'hF && cas_n != 4'hF) cols <= cols + 1;
	end
endmodule

// ==== test/adbd_ctrl_test.sv ====
// Self-checking bench for the two-block decode and strobe timing controller.
// Assumes the package, the design, the checker bind and the memory model are compiled first.
module adbd_ctrl_test import adbd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RC = 32;
	logic clk, rst_n, reg_wr, reg_rd, acc_req, acc_write, acc_ready, acc_ack, acc_done, acc_miss, dramw_n, miss;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, acc_addr, c0, m0, a, d;
	logic [1:0] acc_size, ras_n;
	logic [3:0] cas_n;
	logic [7:0] ofs [7] = '{ADBD_OFS_CTRL0, ADBD_OFS_CTRL1, ADBD_OFS_MASK0, ADBD_OFS_MASK1, ADBD_OFS_MODE,
		ADBD_OFS_STATUS, 8'h20};
	int rows0, rows1, wrows, cols, err_total, n_tests, seed, n_ack, r0, w0, k0, i, ps, sz, pm;
	logic wb;

	adbd_ctrl #(.REFRESH_CYCLES(RC)) uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req), .acc_addr(acc_addr),
		.acc_size(acc_size), .acc_write(acc_write), .acc_ready(acc_ready), .acc_ack(acc_ack),
		.acc_done(acc_done), .acc_miss(acc_miss), .ras_n(ras_n), .cas_n(cas_n), .dramw_n(dramw_n));
	adbd_dram_model mem (.clk(clk), .ras_n(ras_n), .cas_n(cas_n), .dramw_n(dramw_n),
		.rows0(rows0), .rows1(rows1), .wrows(wrows), .cols(cols));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ----------------------------------------
	// Tasks and expectations
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] dv);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= dv;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] dv);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		dv = reg_rdata;
	endtask
	task automatic access(input logic [31:0] ad, input logic [1:0] s, input logic w);
		int t;
		n_ack = 0;
		miss = 1'b0;
		t = 0;
		@(posedge clk);
		acc_req <= 1'b1;
		acc_addr <= ad;
		acc_size <= s;
		acc_write <= w;
		do begin
			@(posedge clk);
			t++;
		end while (!(acc_req === 1'b1 && acc_ready === 1'b1) && t < 100);
		if (acc_ready !== 1'b1) begin
			err_total++;
			end_of_test();
		end
		acc_req <= 1'b0;
		for (t = 0; t < 1000 && acc_done !== 1'b1 && acc_miss !== 1'b1; t++) begin
			@(posedge clk);
			n_ack += (acc_ack === 1'b1);
			miss = acc_miss;
		end
		if (t >= 1000) begin
			err_total++;
			end_of_test();
		end
	endtask
	function automatic int beats(input int psz, input int s);
		int by;
		int wd;
		by = (s == 0) ? 4 : (s == 3) ? 16 : s;
		wd = (psz == 0) ? 4 : (psz == 1) ? 1 : 2;
		return (by > wd) ? by / wd : 1;
	endfunction
	function automatic int rows_exp(input int psz, input int s, input int pmode);
		if ((pmode == 1 && s == 3) || (pmode == 3 && beats(psz, s) > 1)) return 1;
		return beats(psz, s);
	endfunction
	function automatic logic hit(input logic [31:0] ad, input logic [31:0] c, input logic [31:0] m);
		return ((ad[31:18] ^ c[31:18]) & ~m[31:18]) == 14'h0;
	endfunction
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 60;
		err_total = 0;
		n_tests = 0;
		{rst_n, reg_wr, reg_rd, acc_req, acc_write, reg_addr, reg_wdata, acc_addr, acc_size} = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 7; i++) begin
			rd(ofs[i], d);
			check(d, 32'h0000_0000);
		end
		for (i = 0; i < 4; i++) begin
			d = $random(seed) & ~32'h0000_8000;
			wr(ofs[i % 2], d);
			rd(ofs[i % 2], a);
			check(a, d & ~32'h0003_4083);
		end
		wr(ADBD_OFS_CTRL1, 32'h8000_0000);
		wr(ADBD_OFS_MASK1, 32'h3FFC_0000);
		for (i = 0; i < 64; i++) begin
			ps = i % 4;
			sz = (i / 4) % 4;
			pm = i / 16;
			wr(ADBD_OFS_MASK0, 32'h0000_0000);
			wr(ADBD_OFS_CTRL0, ($random(seed) & 32'h0000_3F40) | 32'(ps << 4) | 32'(pm << 2));
			a = $random(seed) & 32'h0003_FFFF;
			wb = $random(seed);
			r0 = rows0;
			w0 = wrows;
			k0 = cols;
			access(a, 2'(sz), wb);
			check(miss, 1'b0);
			check(n_ack, beats(ps, sz));
			check(cols - k0, beats(ps, sz));
			check(rows0 - r0, rows_exp(ps, sz, pm));
			check(wrows - w0, wb ? rows_exp(ps, sz, pm) : 0);
		end
		for (i = 0; i < 24; i++) begin
			c0 = $random(seed) & 32'h7FFC_0000;
			m0 = $random(seed) & 32'h7FFC_0000;
			wr(ADBD_OFS_CTRL0, c0);
			wr(ADBD_OFS_MASK0, m0);
			a = (i % 2) ? ((c0 ^ ($random(seed) & m0)) | ($random(seed) & 32'h0003_FFFF)) : $random(seed);
			access(a, 2'h1, 1'b0);
			check(miss, !(hit(a, c0, m0) || hit(a, 32'h8000_0000, 32'h3FFC_0000)));
		end
		wr(ADBD_OFS_MODE, 32'h0000_0001);
		access(32'h8000_0000, 2'h0, 1'b1);
		check(miss, 1'b1);
		wr(ADBD_OFS_MODE, 32'h0000_0000);
		wr(ADBD_OFS_CTRL1, 32'h8000_8000);
		r0 = rows0;
		w0 = rows1;
		repeat (4 * RC) @(posedge clk);
		check(rows0 - r0, 0);
		check(32'(rows1 - w0 >= 3), 1);
		wr(ADBD_OFS_CTRL1, 32'h8000_0000);
		repeat (10) @(posedge clk);
		w0 = rows1;
		repeat (4 * RC) @(posedge clk);
		check(rows1 - w0, 0);
		end_of_test();
	end
endmodule
